// File: design/tec_timer_event_counter.sv
// Three timer/event counters with prescalers, preload, pulse-width mode and register port.
`timescale 1ns/1ps

// Function
// - Control bits 0..2 divide the selected internal clock by 1 to 128.
// - Mode bits: 01 event, 10 timer, 11 pulse width, 00 unused.
// - Event mode counts falling pin edges when edge bit is 1, else rising.
// - Pulse mode starts on rising and stops on falling when edge bit 1, else reversed.
// - Counting happens only while control bit 4 is set.
// - Third counter bit 5 picks system clock over four or dedicated timer clock.
// - Event mode counts pin pulses; timer and pulse modes count the internal source.
// - Event and timer modes count up from present value to all ones.
// - Overflow reloads the preload value and sets the request flag.
// - Pulse mode stops when the pin returns and clears the run bit itself.
// - Finished measurement is kept; later start edges ignored until run is set again.
// - Overflow during pulse measurement reloads and raises the request too.
// - Event and timer modes never clear the run bit by hardware.
// - Every counter overflow produces a wake-up pulse.
// - A cleared interrupt enable bit suppresses that counter's request output.
// - Preload write while stopped also loads the counter.
// - Preload write while running only updates preload; count continues.
// - Reading a counter blocks its count clock for that cycle.
// - First counter bit 5 picks system clock or low-frequency clock.
// - Second counter bit 5 picks system clock over four or low-frequency clock.
module tec_timer_event_counter #(
  parameter int unsigned CNT0_W = tec_pkg::TEC_CNT0_W,
  parameter int unsigned CNT1_W = tec_pkg::TEC_CNT1_W,
  parameter int unsigned CNT2_W = tec_pkg::TEC_CNT2_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire tec_pkg::tec_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic first_event_pin,
  input wire logic second_event_pin,
  input wire logic third_event_pin,
  input wire logic low_freq_clock,
  input wire logic dedicated_timer_clock,
  output logic [2:0] irq_req,
  output logic wake_up
);

  localparam int unsigned CNT_W [3] = '{CNT0_W, CNT1_W, CNT2_W};

  tec_pkg::tec_state_t s_reg;
  tec_pkg::tec_state_t s_next;
  logic [tec_pkg::TEC_NSYNC-1:0] raw_in;
  logic [tec_pkg::TEC_NSYNC-1:0] rise;
  logic [tec_pkg::TEC_NSYNC-1:0] fall;
  logic div4_tick;
  logic [2:0] src_tick;
  logic [2:0] pre_hit;
  logic [2:0] act_edge;
  logic [2:0] start_edge;
  logic [2:0] stop_edge;
  logic [2:0] rd_block;
  logic [2:0] tick;
  logic [2:0] ovf;
  logic [6:0] psc_mask [3];
  logic [15:0] full_val [3];
  tec_pkg::tec_mode_t mode [3];

  assign raw_in = {dedicated_timer_clock, low_freq_clock, third_event_pin,
                   second_event_pin, first_event_pin};

  always_comb begin
    s_next = s_reg;
    rise = '0;
    fall = '0;
    src_tick = '0;
    pre_hit = '0;
    act_edge = '0;
    start_edge = '0;
    stop_edge = '0;
    rd_block = '0;
    tick = '0;
    ovf = '0;
    for (int i = 0; i < 3; i++) begin
      psc_mask[i] = '0;
      full_val[i] = '0;
      mode[i] = tec_pkg::TEC_MODE_OFF;
    end

    // Pins and foreign clocks: a change is taken once the second and third stages agree.
    for (int k = 0; k < tec_pkg::TEC_NSYNC; k++) begin
      s_next.sync[k].ff = {s_reg.sync[k].ff[1:0], raw_in[k]};
      if (s_reg.sync[k].ff[1] == s_reg.sync[k].ff[2]) begin
        s_next.sync[k].lvl = s_reg.sync[k].ff[2];
      end
      rise[k] = s_next.sync[k].lvl & ~s_reg.sync[k].lvl;
      fall[k] = ~s_next.sync[k].lvl & s_reg.sync[k].lvl;
    end

    s_next.div4 = s_reg.div4 + 2'h1;
    div4_tick = (s_reg.div4 == tec_pkg::TEC_DIV4_LAST);

    // Internal source selection per counter; the low-frequency and timer clocks are
    // slow against the system clock, so their rising edges serve as count ticks.
    if (s_reg.chan[0].ctrl[tec_pkg::TEC_SRC_BIT]) begin
      src_tick[0] = rise[tec_pkg::TEC_SYNC_FL];
    end else begin
      src_tick[0] = 1'b1;
    end
    if (s_reg.chan[1].ctrl[tec_pkg::TEC_SRC_BIT]) begin
      src_tick[1] = rise[tec_pkg::TEC_SYNC_FL];
    end else begin
      src_tick[1] = div4_tick;
    end
    if (s_reg.chan[2].ctrl[tec_pkg::TEC_SRC_BIT]) begin
      src_tick[2] = rise[tec_pkg::TEC_SYNC_TCK];
    end else begin
      src_tick[2] = div4_tick;
    end

    s_next.rdata = 8'h00;
    s_next.wake = 1'b0;

    for (int i = 0; i < 3; i++) begin
      mode[i] = tec_pkg::tec_mode_t'(
        s_reg.chan[i].ctrl[tec_pkg::TEC_MODE_MSB:tec_pkg::TEC_MODE_LSB]);
      full_val[i] = 16'((32'h1 << CNT_W[i]) - 32'h1);

      // Prescaler: a tick passes when the low psc bits have all come round.
      psc_mask[i] = 7'((8'h1 << s_reg.chan[i].ctrl[tec_pkg::TEC_PSC_MSB:tec_pkg::TEC_PSC_LSB])
                       - 8'h1);
      pre_hit[i] = src_tick[i] & ((s_reg.chan[i].psc & psc_mask[i]) == psc_mask[i]);
      if (!s_reg.chan[i].ctrl[tec_pkg::TEC_RUN_BIT]) begin
        s_next.chan[i].psc = 7'h00;
      end else if (src_tick[i]) begin
        s_next.chan[i].psc = s_reg.chan[i].psc + 7'h01;
      end

      if (s_reg.chan[i].ctrl[tec_pkg::TEC_EDGE_BIT]) begin
        act_edge[i] = fall[i];
        start_edge[i] = rise[i];
        stop_edge[i] = fall[i];
      end else begin
        act_edge[i] = rise[i];
        start_edge[i] = fall[i];
        stop_edge[i] = rise[i];
      end

      // A read of the counter steals its tick so the value cannot tear under the read.
      rd_block[i] = bus_req.rd && ((bus_req.addr == tec_pkg::TEC_LO_ADDR[i]) ||
                    ((CNT_W[i] > 8) && (bus_req.addr == tec_pkg::TEC_HI_ADDR[i])));

      case (mode[i])
        tec_pkg::TEC_MODE_EVT: begin
          tick[i] = s_reg.chan[i].ctrl[tec_pkg::TEC_RUN_BIT] & act_edge[i];
        end
        tec_pkg::TEC_MODE_TMR: begin
          tick[i] = s_reg.chan[i].ctrl[tec_pkg::TEC_RUN_BIT] & pre_hit[i];
        end
        tec_pkg::TEC_MODE_PW: begin
          tick[i] = s_reg.chan[i].ctrl[tec_pkg::TEC_RUN_BIT] & s_reg.chan[i].meas
                    & pre_hit[i];
          if (s_reg.chan[i].ctrl[tec_pkg::TEC_RUN_BIT] && !s_reg.chan[i].meas &&
              start_edge[i]) begin
            s_next.chan[i].meas = 1'b1;
          end
          if (s_reg.chan[i].meas && stop_edge[i]) begin
            s_next.chan[i].meas = 1'b0;
            // Run drops so further start edges leave the result alone.
            s_next.chan[i].ctrl[tec_pkg::TEC_RUN_BIT] = 1'b0;
          end
        end
        default: begin
          tick[i] = 1'b0;
        end
      endcase
      // Event and timer branches above never touch the run bit.
      tick[i] = tick[i] & ~rd_block[i];

      // Preload writes come before the tick so a same-cycle reload sees the new value.
      if (bus_req.wr && bus_req.addr == tec_pkg::TEC_LO_ADDR[i]) begin
        s_next.chan[i].pre[7:0] = bus_req.wdata;
        if (!s_reg.chan[i].ctrl[tec_pkg::TEC_RUN_BIT]) begin
          s_next.chan[i].cnt[7:0] = bus_req.wdata;
        end
      end
      if ((CNT_W[i] > 8) && bus_req.wr && bus_req.addr == tec_pkg::TEC_HI_ADDR[i]) begin
        s_next.chan[i].pre[15:8] = bus_req.wdata;
        if (!s_reg.chan[i].ctrl[tec_pkg::TEC_RUN_BIT]) begin
          s_next.chan[i].cnt[15:8] = bus_req.wdata;
        end
      end
      s_next.chan[i].pre = s_next.chan[i].pre & full_val[i];
      s_next.chan[i].cnt = s_next.chan[i].cnt & full_val[i];

      if (tick[i]) begin
        if (s_reg.chan[i].cnt == full_val[i]) begin
          ovf[i] = 1'b1;
          s_next.chan[i].cnt = s_next.chan[i].pre;
        end else begin
          s_next.chan[i].cnt = s_reg.chan[i].cnt + 16'h0001;
        end
      end

      // Control write lands last: software setting run re-arms a finished measurement.
      if (bus_req.wr && bus_req.addr == tec_pkg::TEC_CTRL_ADDR[i]) begin
        s_next.chan[i].ctrl = bus_req.wdata;
        s_next.chan[i].meas = 1'b0;
      end

      // Flag register write; a hardware set in the same cycle wins over a clear.
      if (bus_req.wr && bus_req.addr == tec_pkg::TEC_ADDR_IRQ) begin
        s_next.chan[i].flag = bus_req.wdata[tec_pkg::TEC_FLAG_LSB + i];
        s_next.chan[i].ien = bus_req.wdata[tec_pkg::TEC_IEN_LSB + i];
      end
      if (ovf[i]) begin
        s_next.chan[i].flag = 1'b1;
        s_next.wake = 1'b1;
      end
      s_next.irq[i] = s_next.chan[i].flag & s_next.chan[i].ien;

      // Reads: the low byte snapshots the high byte so a two-byte read is coherent.
      if (bus_req.rd) begin
        if (bus_req.addr == tec_pkg::TEC_CTRL_ADDR[i]) begin
          s_next.rdata = s_reg.chan[i].ctrl;
        end else if (bus_req.addr == tec_pkg::TEC_LO_ADDR[i]) begin
          s_next.rdata = s_reg.chan[i].cnt[7:0];
          s_next.chan[i].hi_latch = s_reg.chan[i].cnt[15:8];
        end else if ((CNT_W[i] > 8) && bus_req.addr == tec_pkg::TEC_HI_ADDR[i]) begin
          s_next.rdata = s_reg.chan[i].hi_latch;
        end
      end
    end

    if (bus_req.rd && bus_req.addr == tec_pkg::TEC_ADDR_IRQ) begin
      s_next.rdata = {1'b0, s_reg.chan[2].ien, s_reg.chan[1].ien, s_reg.chan[0].ien,
                      1'b0, s_reg.chan[2].flag, s_reg.chan[1].flag, s_reg.chan[0].flag};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= tec_pkg::TEC_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rdata;
  assign irq_req = s_reg.irq;
  assign wake_up = s_reg.wake;

endmodule

// File: design/tec_pkg.sv
// Shared constants and types for the three-channel timer/event counter block.
package tec_pkg;

  // Register addresses on the byte-wide register port.
  localparam logic [7:0] TEC_ADDR_IRQ = 8'h0b;
  localparam logic [7:0] TEC_ADDR_CNT0 = 8'h0d;
  localparam logic [7:0] TEC_ADDR_CTRL0 = 8'h0e;
  localparam logic [7:0] TEC_ADDR_CNT1_LO = 8'h0f;
  localparam logic [7:0] TEC_ADDR_CNT1_HI = 8'h10;
  localparam logic [7:0] TEC_ADDR_CTRL1 = 8'h11;
  localparam logic [7:0] TEC_ADDR_CNT2_LO = 8'h15;
  localparam logic [7:0] TEC_ADDR_CNT2_HI = 8'h16;
  localparam logic [7:0] TEC_ADDR_CTRL2 = 8'h17;

  localparam logic [7:0] TEC_CTRL_ADDR [3] = '{TEC_ADDR_CTRL0, TEC_ADDR_CTRL1, TEC_ADDR_CTRL2};
  localparam logic [7:0] TEC_LO_ADDR [3] = '{TEC_ADDR_CNT0, TEC_ADDR_CNT1_LO, TEC_ADDR_CNT2_LO};
  localparam logic [7:0] TEC_HI_ADDR [3] = '{TEC_ADDR_CNT0, TEC_ADDR_CNT1_HI, TEC_ADDR_CNT2_HI};

  // Control register field positions.
  localparam int unsigned TEC_PSC_LSB = 0;
  localparam int unsigned TEC_PSC_MSB = 2;
  localparam int unsigned TEC_EDGE_BIT = 3;
  localparam int unsigned TEC_RUN_BIT = 4;
  localparam int unsigned TEC_SRC_BIT = 5;
  localparam int unsigned TEC_MODE_LSB = 6;
  localparam int unsigned TEC_MODE_MSB = 7;

  // Flag/enable register field positions.
  localparam int unsigned TEC_FLAG_LSB = 0;
  localparam int unsigned TEC_IEN_LSB = 4;

  // Default counter widths.
  localparam int unsigned TEC_CNT0_W = 8;
  localparam int unsigned TEC_CNT1_W = 16;
  localparam int unsigned TEC_CNT2_W = 16;

  // Number of inputs that arrive from outside the clock domain.
  localparam int unsigned TEC_NSYNC = 5;
  localparam int unsigned TEC_SYNC_FL = 3;
  localparam int unsigned TEC_SYNC_TCK = 4;

  // System clock divided by four fires when the divider shows this value.
  localparam logic [1:0] TEC_DIV4_LAST = 2'h3;

  typedef enum logic [1:0] {
    TEC_MODE_OFF,
    TEC_MODE_EVT,
    TEC_MODE_TMR,
    TEC_MODE_PW
  } tec_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tec_bus_req_t;

  typedef struct packed {
    logic [2:0] ff;
    logic lvl;
  } tec_sync_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] cnt;
    logic [15:0] pre;
    logic [6:0] psc;
    logic meas;
    logic [7:0] hi_latch;
    logic flag;
    logic ien;
  } tec_chan_t;

  typedef struct packed {
    tec_chan_t [2:0] chan;
    tec_sync_t [TEC_NSYNC-1:0] sync;
    logic [1:0] div4;
    logic [7:0] rdata;
    logic [2:0] irq;
    logic wake;
  } tec_state_t;

  localparam tec_state_t TEC_STATE_RST = '0;

endpackage

// File: tb/tec_pin_model.sv
// Behavioural source of an external event or pulse signal on a counter pin.
`timescale 1ns/1ps
module tec_pin_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [7:0] toggles,
  input wire logic [7:0] half,
  output logic pin,
  output logic busy
);
  logic [7:0] left_reg;
  logic [7:0] tmr_reg;
  initial begin
    pin = 1'b0;
    left_reg = 8'h00;
    tmr_reg = 8'h00;
  end
  // The pin moves only on request, so no stray edges reach an armed counter.
  always @(posedge ref_clk) begin
    if (go) begin
      left_reg <= toggles;
      tmr_reg <= half;
    end else if (left_reg != 8'h00) begin
      if (tmr_reg <= 8'h01) begin
        pin <= ~pin;
        left_reg <= left_reg - 8'h01;
        tmr_reg <= half;
      end else begin
        tmr_reg <= tmr_reg - 8'h01;
      end
    end
  end
  assign busy = (left_reg != 8'h00);
endmodule

// File: tb/tec_timer_event_counter_props.sv
// Port-level assertions for the timer/event counter block.
`timescale 1ns/1ps
module tec_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire tec_pkg::tec_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic [2:0] irq_req,
  input wire logic wake_up
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic armed_reg;
  logic ctrl_wr;
  logic irq_wr;
  assign ctrl_wr = bus_req.wr && (bus_req.addr inside {tec_pkg::TEC_ADDR_CTRL0,
    tec_pkg::TEC_ADDR_CTRL1, tec_pkg::TEC_ADDR_CTRL2});
  assign irq_wr = bus_req.wr && bus_req.addr == tec_pkg::TEC_ADDR_IRQ;
  // Only a running counter in a real mode can overflow; software may also set a flag itself.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if ((ctrl_wr && bus_req.wdata[4] && bus_req.wdata[7:6] != 2'h0) ||
        (irq_wr && bus_req.wdata[2:0] != 3'h0)) begin
      armed_reg <= 1'b1;
    end
  end
  sequence s_ctrl_wr;
    ctrl_wr && bus_req.wdata[7:6] != 2'h3;
  endsequence
  sequence s_ien_off;
    irq_wr && bus_req.wdata[6:4] == 3'h0;
  endsequence
  property p_rd_idle;
    !$past(bus_req.rd) |-> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_unmapped;
    bus_req.rd && !(bus_req.addr inside {[8'h0b:8'h0b], [8'h0d:8'h11], [8'h15:8'h17]})
      |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ien_off;
    s_ien_off ##1 !irq_wr |-> ##1 irq_req == 3'h0;
  endproperty
  a_ien_off: assert property (p_ien_off) else $error("request while disabled");
  property p_irq_wake;
    (|(irq_req & ~$past(irq_req))) && !$past(bus_req.wr) && !$past(bus_req.wr, 2) |-> wake_up;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("overflow without wake");
  property p_no_wake;
    !armed_reg |-> !wake_up && irq_req == 3'h0;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("overflow while idle");
  property p_ctrl_rb;
    s_ctrl_wr ##1 (bus_req.rd && bus_req.addr == $past(bus_req.addr))
      |=> rd_data == $past(bus_req.wdata, 2);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_ien_rb;
    irq_wr ##1 (bus_req.rd && bus_req.addr == tec_pkg::TEC_ADDR_IRQ)
      |=> (rd_data & 8'h70) == ($past(bus_req.wdata, 2) & 8'h70);
  endproperty
  a_ien_rb: assert property (p_ien_rb) else $error("enable readback wrong");
  property p_preload_stop;
    (ctrl_wr && bus_req.addr == tec_pkg::TEC_ADDR_CTRL0 && !bus_req.wdata[4])
      ##1 (bus_req.wr && bus_req.addr == tec_pkg::TEC_ADDR_CNT0)
      ##1 (bus_req.rd && bus_req.addr == tec_pkg::TEC_ADDR_CNT0)
      |=> rd_data == $past(bus_req.wdata, 2);
  endproperty
  a_preload_stop: assert property (p_preload_stop) else $error("stopped load lost");
endmodule
bind tec_timer_event_counter tec_props u_props (.ref_clk(ref_clk), .rst(rst),
  .bus_req(bus_req), .rd_data(rd_data), .irq_req(irq_req), .wake_up(wake_up));

// File: tb/timer_event_counter_tb.sv
// Self-checking testbench for the timer/event counter block.
`timescale 1ns/1ps
module timer_event_counter_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  tec_pkg::tec_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic [2:0] irq_req;
  logic wake_up;
  logic [4:0] slow_cnt = 5'h00;
  logic go = 1'b0;
  logic [7:0] toggles = 8'h00;
  logic [7:0] half = 8'h08;
  logic pin;
  logic busy;
  int fail_count = 0;
  int compares = 0;
  int seed = 35;
  // One pin source feeds all three counters; only the counter under test is armed.
  tec_timer_event_counter dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
    .rd_data(rd_data), .first_event_pin(pin), .second_event_pin(pin),
    .third_event_pin(pin), .low_freq_clock(slow_cnt[4]),
    .dedicated_timer_clock(slow_cnt[3]), .irq_req(irq_req), .wake_up(wake_up));
  tec_pin_model u_pin (.ref_clk(ref_clk), .go(go), .toggles(toggles), .half(half),
    .pin(pin), .busy(busy));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) slow_cnt <= slow_cnt + 5'h01;
  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", name, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 v = rd_data;
  endtask
  task automatic load(input int ch, input logic [15:0] v);
    logic [7:0] g;
    wr(tec_pkg::TEC_CTRL_ADDR[ch], 8'h00);
    wr(tec_pkg::TEC_LO_ADDR[ch], v[7:0]);
    if (ch != 0) wr(tec_pkg::TEC_HI_ADDR[ch], v[15:8]);
    rd(tec_pkg::TEC_LO_ADDR[ch], g);
    chk("count_lo", v[7:0], g);
    if (ch != 0) begin
      rd(tec_pkg::TEC_HI_ADDR[ch], g);
      chk("count_hi", v[15:8], g);
    end
  endtask
  // Runs one counter from a start value up to its first overflow.
  task automatic overflow(input int ch, input logic [7:0] cfg, input logic [15:0] s,
      input logic [7:0] pv, output int n);
    logic [7:0] g;
    n = 3;
    load(ch, s);
    wr(tec_pkg::TEC_CTRL_ADDR[ch], cfg);
    rd(tec_pkg::TEC_CTRL_ADDR[ch], g);
    wr(tec_pkg::TEC_LO_ADDR[ch], pv);
    while (wake_up !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("wake", 1'b1, wake_up);
    chk("irq", 1'b1, irq_req[ch]);
    rd(tec_pkg::TEC_CTRL_ADDR[ch], g);
    chk("ctrl_run", cfg, g);
    wr(tec_pkg::TEC_CTRL_ADDR[ch], 8'h00);
    wr(tec_pkg::TEC_ADDR_IRQ, 8'h70);
  endtask
  function automatic int exp_edges(logic lvl, int k, logic fall);
    int c;
    c = 0;
    for (int i = 0; i < k; i++) begin
      lvl = ~lvl;
      c += (lvl != fall);
    end
    return c;
  endfunction
  task automatic pulse(input int k, input logic [7:0] h);
    int w;
    w = 0;
    toggles <= k[7:0];
    half <= h;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
    while (busy !== 1'b0 && w < 3000) begin
      @(posedge ref_clk);
      #1 w++;
    end
    chk("pin_busy", 1'b0, busy);
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  logic [7:0] ev_cfg [4] = '{8'h50, 8'h58, 8'h40, 8'h10};
  initial begin
    logic [7:0] g;
    logic [7:0] pv;
    int n;
    int k;
    int e;
    int c;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    rd(8'h00, g);
    chk("unmapped", 8'h00, g);
    wr(tec_pkg::TEC_ADDR_IRQ, 8'h70);
    rd(tec_pkg::TEC_ADDR_IRQ, g);
    chk("irq_en", 8'h70, g & 8'h70);
    for (int p = 0; p < 8; p++) begin
      pv = $random(seed);
      overflow(0, 8'h90 | p[7:0], 16'h00fc, pv, n);
      if (n < (3 << p) + 1 || n > (4 << p) + 8) chk("psc_cycles", p, 16'hffff);
      rd(tec_pkg::TEC_ADDR_CNT0, g);
      if (p == 7) chk("reload", pv, g);
    end
    overflow(0, 8'hb0, 16'h00fe, 8'h00, n);
    overflow(1, 8'h90, 16'hfffd, 8'h00, n);
    overflow(1, 8'hb0, 16'hfffe, 8'h00, n);
    overflow(2, 8'h90, 16'hfffd, 8'h00, n);
    overflow(2, 8'hb0, 16'hfffe, 8'h00, n);
    // Back-to-back reads of a counter that ticks every cycle must find it frozen at zero.
    load(0, 16'h0000);
    wr(tec_pkg::TEC_ADDR_CTRL0, 8'h90);
    rd(tec_pkg::TEC_ADDR_CNT0, pv);
    rd(tec_pkg::TEC_ADDR_CNT0, g);
    chk("rd_block_first", 8'h00, pv);
    chk("rd_block_second", 8'h00, g);
    wr(tec_pkg::TEC_ADDR_CTRL0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      k = 1 + ($unsigned($random(seed)) % 7);
      c = i % 3;
      e = (i % 4 < 2) ? exp_edges(pin, k, ev_cfg[i % 4][3]) : 0;
      load(c, 16'h0000);
      wr(tec_pkg::TEC_CTRL_ADDR[c], ev_cfg[i % 4]);
      pulse(k, 8'h08);
      wr(tec_pkg::TEC_CTRL_ADDR[c], 8'h00);
      rd(tec_pkg::TEC_LO_ADDR[c], g);
      chk("events", e[7:0], g);
    end
    if (pin) pulse(1, 8'h08);
    load(1, 16'h0000);
    wr(tec_pkg::TEC_ADDR_CTRL1, 8'hd8);
    pulse(2, 8'h28);
    rd(tec_pkg::TEC_ADDR_CNT1_LO, pv);
    if (pv < 8'h09 || pv > 8'h0b) chk("width", 8'h0a, pv);
    rd(tec_pkg::TEC_ADDR_CTRL1, g);
    chk("pw_run", 8'hc8, g);
    pulse(2, 8'h28);
    rd(tec_pkg::TEC_ADDR_CNT1_LO, g);
    chk("pw_hold", pv, g);
    wr(tec_pkg::TEC_ADDR_IRQ, 8'h00);
    repeat (4) @(posedge ref_clk);
    #1 chk("irq_off", 3'h0, irq_req);
    print_verdict();
  end
endmodule
